// *** rtl/ief_map.vh ***
// Purpose: Register offsets, field positions and reset values of the interrupt enable and flag block
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Registers hold 8 bits in the low lane, except option: edge select in bit 0, pin mask in bits 13:8; other bits read as zero
`ifndef IEF_MAP_VH
`define IEF_MAP_VH

`define IEF_OFF_INTERRUPT_CONTROL      4'h0
`define IEF_OFF_PERIPH_IRQ_ENABLE      4'h4
`define IEF_OFF_PERIPH_IRQ_REQUEST     4'h8
`define IEF_OFF_OPTION                 4'hc
`define IEF_ADDR_W                     4

// Interrupt control fields
`define IEF_GLOBAL_EN_BIT              7
`define IEF_GROUP_EN_BIT               6
`define IEF_TZ_EN_BIT                  5
`define IEF_EXTIE_BIT                  4
`define IEF_PCIE_BIT                   3
`define IEF_TZ_FLAG_BIT                2
`define IEF_EXTIF_BIT                  1
`define IEF_PCIF_BIT                   0

// Option fields
`define IEF_EDGE_BIT                   0
`define IEF_PCMASK_LSB                 8
`define IEF_PCMASK_MSB                 13

`define IEF_CTRL_EN_RESET              5'h00
`define IEF_CTRL_FLAG_RESET            3'h0
`define IEF_PIE_RESET                  8'h00
`define IEF_PIR_RESET                  8'h00
`define IEF_EDGE_RESET                 1'b1
`define IEF_PCMASK_RESET               6'h00
`define IEF_PORT_W                     6

`endif

// *** rtl/ief_interrupt_enable_flag_logic.v ***
// Purpose: Interrupt enable and flag logic with one request to the core
// Assumes: Rollover and peripheral event inputs are one-cycle pulses synchronous to clk; pin and port inputs are levels
// Notes:   Registers reached over classic Wishbone
// Operation
// - Global enable gates every interrupt request
// - Group enable passes or blocks peripheral sources
// - Timer zero enable masks overflow flag
// - External pin enable masks pin flag
// - Port change needs enable and pin mask
// - Timer zero rollover sets sticky flag
// - Reset leaves timer count untouched
// - External pin event sets sticky flag
// - Any monitored port pin change sets flag
// - Peripheral sources need group enable too
// - Write complete enable masks its flag
// - Converter enable masks conversion done flag
// - Capture compare enable masks its flag
// - Comparator two enable masks its flag
// - Comparator one enable masks its flag
// - Clock fail enable masks its flag
// - Timer two match enable masks flag
// - Timer one enable masks overflow flag
// - Flags set regardless of enables
// - Edge select picks rising or falling
`include "ief_map.vh"
`timescale 1ns/1ns
`default_nettype none

module ief_interrupt_enable_flag_logic (
   input  wire        clk,
   input  wire        resetn,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [31:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        timer_zero_rollover,
   input  wire        ext_irq_pin,
   input  wire [5:0]  gp_port,
   input  wire [7:0]  periph_event,
   output reg         irq_request
);

   reg  [7:0] interrupt_control;
   reg  [7:0] peripheral_interrupt_enable;
   reg  [7:0] peripheral_interrupt_request;
   reg        ext_edge_select;
   reg  [5:0] pin_change_mask;
   reg        ext_pin_last;
   reg  [5:0] port_last;
   reg        port_valid;

   wire       access;
   wire       wr_lane0;
   wire       wr_lane1;
   wire [3:0] offset;
   wire       ext_event;
   wire       port_event;
   wire       next_irq;
   reg  [31:0] next_dat;

   // Register index decode, used by read mux and write paths
   function hit;
      input [3:0] addr;
      input [3:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   assign access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign offset   = wb_adr_i[3:0];
   assign wr_lane0 = access & wb_we_i & wb_sel_i[0];
   assign wr_lane1 = access & wb_we_i & wb_sel_i[1];

   // Pin sampled once; edge detect compares against last sample
   assign ext_event = ext_edge_select ? (ext_irq_pin & ~ext_pin_last)
                                      : (~ext_irq_pin & ext_pin_last);
   // First sample after reset has no history, so no change is reported
   assign port_event = port_valid & (|((gp_port ^ port_last) & pin_change_mask));

   assign next_irq = interrupt_control[`IEF_GLOBAL_EN_BIT] & (
      (interrupt_control[`IEF_TZ_EN_BIT] & interrupt_control[`IEF_TZ_FLAG_BIT]) |
      (interrupt_control[`IEF_EXTIE_BIT] & interrupt_control[`IEF_EXTIF_BIT]) |
      (interrupt_control[`IEF_PCIE_BIT] & interrupt_control[`IEF_PCIF_BIT]) |
      (interrupt_control[`IEF_GROUP_EN_BIT] &
       (|(peripheral_interrupt_enable & peripheral_interrupt_request))));

   always @* begin
      next_dat = 32'h0000_0000;
      if (hit(offset, `IEF_OFF_INTERRUPT_CONTROL))
         next_dat[7:0] = interrupt_control;
      else if (hit(offset, `IEF_OFF_PERIPH_IRQ_ENABLE))
         next_dat[7:0] = peripheral_interrupt_enable;
      else if (hit(offset, `IEF_OFF_PERIPH_IRQ_REQUEST))
         next_dat[7:0] = peripheral_interrupt_request;
      else if (hit(offset, `IEF_OFF_OPTION)) begin
         next_dat[`IEF_EDGE_BIT] = ext_edge_select;
         next_dat[`IEF_PCMASK_MSB:`IEF_PCMASK_LSB] = pin_change_mask;
      end
   end

   // Bus slave: ack one cycle after request, unmapped reads give zero
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= access ? next_dat : 32'h0000_0000;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ext_pin_last <= 1'b0;
         port_last    <= 6'h00;
         port_valid   <= 1'b0;
         irq_request  <= 1'b0;
      end else begin
         ext_pin_last <= ext_irq_pin;
         port_last    <= gp_port;
         port_valid   <= 1'b1;
         irq_request  <= next_irq;
      end
   end

   // Enables and options; the timer count lives outside, so reset here never touches it
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_control[7:3]      <= `IEF_CTRL_EN_RESET;
         peripheral_interrupt_enable <= `IEF_PIE_RESET;
         ext_edge_select             <= `IEF_EDGE_RESET;
         pin_change_mask             <= `IEF_PCMASK_RESET;
      end else begin
         if (wr_lane0 && hit(offset, `IEF_OFF_INTERRUPT_CONTROL))
            interrupt_control[7:3] <= wb_dat_i[7:3];
         if (wr_lane0 && hit(offset, `IEF_OFF_PERIPH_IRQ_ENABLE))
            peripheral_interrupt_enable <= wb_dat_i[7:0];
         if (wr_lane0 && hit(offset, `IEF_OFF_OPTION))
            ext_edge_select <= wb_dat_i[`IEF_EDGE_BIT];
         if (wr_lane1 && hit(offset, `IEF_OFF_OPTION))
            pin_change_mask <= wb_dat_i[`IEF_PCMASK_MSB:`IEF_PCMASK_LSB];
      end
   end

   // Sticky flags: software writes, but a same-cycle event wins over a clear
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_control[2:0]       <= `IEF_CTRL_FLAG_RESET;
         peripheral_interrupt_request <= `IEF_PIR_RESET;
      end else begin
         if (wr_lane0 && hit(offset, `IEF_OFF_INTERRUPT_CONTROL))
            interrupt_control[2:0] <= wb_dat_i[2:0]
               | {timer_zero_rollover, ext_event, port_event};
         else
            interrupt_control[2:0] <= interrupt_control[2:0]
               | {timer_zero_rollover, ext_event, port_event};
         if (wr_lane0 && hit(offset, `IEF_OFF_PERIPH_IRQ_REQUEST))
            peripheral_interrupt_request <= wb_dat_i[7:0] | periph_event;
         else
            peripheral_interrupt_request <= peripheral_interrupt_request | periph_event;
      end
   end

endmodule // ief_interrupt_enable_flag_logic

`default_nettype wire

// *** testbench/ief_checker.sv ***
// Purpose: Port assertions for the interrupt enable and flag block
// Assumes: Wishbone ack one cycle after the taking edge
// Notes:   Flags are internal, so request checks tie to bus writes
`timescale 1ns/1ns
`default_nettype none
module ief_checker (
   input wire logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
   input wire logic [3:0]  wb_sel_i,
   input wire logic        timer_zero_rollover, ext_irq_pin, irq_request,
   input wire logic [5:0]  gp_port,
   input wire logic [7:0]  periph_event);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence glob_off_wr;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[3:0] == 4'h0 && wb_sel_i[0] && !wb_dat_i[7] && !wb_ack_o ##1 wb_ack_o;
   endsequence
   ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
   dat_upper_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:0] != 4'hc |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper bits set");
   global_off_a: assert property (glob_off_wr |=> !irq_request) else $error("request past global off");
   irq_sticky_a: assert property ($fell(irq_request) |-> $past(wb_ack_o && wb_we_i))
      else $error("request dropped alone");
   irq_cause_a: assert property ($rose(irq_request) |-> $past(timer_zero_rollover || periph_event != 8'h0, 2)
      || $past(wb_ack_o && wb_we_i) || $past(ext_irq_pin, 2) != $past(ext_irq_pin, 3)
      || $past(gp_port, 2) != $past(gp_port, 3))
      else $error("request without cause");
endmodule // ief_checker
bind ief_interrupt_enable_flag_logic ief_checker ief_checker_i (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_ack_o, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .timer_zero_rollover, .ext_irq_pin, .irq_request,
   .gp_port, .periph_event);
`default_nettype wire

// *** testbench/ief_src_model.sv ***
// Purpose: Event sources beside the block
// Assumes: Pulses last one clock
// Notes:   Pins are levels, held until changed
`timescale 1ns/1ns
`default_nettype none
module ief_src_model (
   input  wire logic       clk,
   output var  logic       timer_zero_rollover, ext_irq_pin,
   output var  logic [5:0] gp_port,
   output var  logic [7:0] periph_event);
   initial {timer_zero_rollover, ext_irq_pin, gp_port, periph_event} = 16'h0;
   task automatic fire(input logic t0, input logic [7:0] pe);
      @(posedge clk);
      timer_zero_rollover <= t0;
      periph_event <= pe;
      @(posedge clk);
      timer_zero_rollover <= 1'b0;
      periph_event <= 8'h0;
   endtask
   task automatic drive(input logic pin, input logic [5:0] port);
      @(posedge clk);
      ext_irq_pin <= pin;
      gp_port <= port;
   endtask
endmodule // ief_src_model
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: Register and event tests of the interrupt enable and flag block
// Assumes: Ack and read data taken at the rising edge where ack is high
// Notes:   Bus released only at a rising edge
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_request, timer_zero_rollover, ext_irq_pin;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
   logic [3:0]  wb_sel_i;
   logic [5:0]  gp_port;
   logic [7:0]  periph_event;
   int          n_errors = 0, n_compared = 0;
   ief_interrupt_enable_flag_logic ief_interrupt_enable_flag_logic_i (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_zero_rollover, .ext_irq_pin,
      .gp_port, .periph_event, .irq_request);
   ief_src_model ief_src_model_i (.clk, .timer_zero_rollover, .ext_irq_pin, .gp_port, .periph_event);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic final_report;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic we, input logic [3:0] s, input logic [31:0] d,
                      input logic [31:0] e);
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, s};
      wb_adr_i <= {28'h0, a};
      wb_dat_i <= d;
      // A wait for ack ends when ack is seen; if ack never comes, only the watchdog ends it
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      if (!we) chk(wb_dat_o, e);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d); bus(a, 1'b1, 4'h3, d, 32'h0); endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e); bus(a, 1'b0, 4'h1, 32'h0, e); endtask
   task automatic irq(input logic e); @(negedge clk); chk({31'h0, irq_request}, {31'h0, e}); endtask
   initial begin
      {resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = 72'h0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h4, 32'h0); rd(4'h8, 32'h0); rd(4'h2, 32'h0); rd(4'hc, 32'h1);
      $display("reset test done");
      ief_src_model_i.fire(1'b1, 8'h0); rd(4'h0, 32'h04); irq(1'b0);
      wr(4'h0, 32'ha4); irq(1'b1); wr(4'h0, 32'h24); irq(1'b0);
      wr(4'h0, 32'h0); rd(4'h0, 32'h0);
      $display("timer test done");
      ief_src_model_i.drive(1'b1, 6'h0); rd(4'h0, 32'h02); wr(4'h0, 32'h92); irq(1'b1);
      wr(4'h0, 32'h0); wr(4'hc, 32'h0); ief_src_model_i.drive(1'b0, 6'h0); rd(4'h0, 32'h02);
      $display("pin test done");
      wr(4'h0, 32'h0); ief_src_model_i.drive(1'b0, 6'h01); rd(4'h0, 32'h0);
      wr(4'hc, 32'h3f00); ief_src_model_i.drive(1'b0, 6'h21); rd(4'h0, 32'h01);
      wr(4'h0, 32'h89); irq(1'b1); wr(4'h0, 32'h0);
      $display("port test done");
      for (int i = 0; i < 8; i++) begin
         ief_src_model_i.fire(1'b0, 8'h1 << i); rd(4'h8, 32'h1 << i);
         wr(4'h4, 32'h1 << i); wr(4'h0, 32'h80); irq(1'b0);
         wr(4'h0, 32'hc0); irq(1'b1); wr(4'h8, 32'h0); irq(1'b0);
      end
      $display("peripheral test done");
      final_report;
   end
   initial begin
      #50000;
      n_errors++;
      final_report;
   end
endmodule // tb
`default_nettype wire
